// ---- verilog/dsr_pkg.sv ----
// Package of constants for the decade switch reader.
`default_nettype none
package dsr_pkg;
	localparam int DSR_BUS_W = 18;
	localparam int DSR_ADDR_W = 4;
	localparam logic [3:0] DSR_CLASS = 4'hF;
	localparam int DSR_NUM_SW = 24;
	localparam int DSR_SWNUM_W = 5;
	localparam int DSR_LINES = 10;
	localparam int DSR_VAL_W = 4;
	localparam logic [4:0] DSR_SWNUM_RST = 5'h00;
endpackage
`default_nettype wire

// ---- verilog/dsr_decoder.sv ----
// One-of-ten checker and decimal to binary converter.
`timescale 1ns/1ns
`default_nettype none
module dsr_decoder #(
	parameter int LINES = 10,
	parameter int VAL_W = 4
) (
	input wire logic [LINES-1:0] lines, // Synchronised decimal lines.
	output logic valid, // Exactly one line active.
	output logic [VAL_W-1:0] value // Binary value of the active line.
);
	// Every line index must fit the value width; the counter has one bit more.
	if (LINES < 1 || LINES > (1 << VAL_W)) begin : g_bad_width
		$error("LINES does not fit VAL_W");
	end
	logic [VAL_W-1:0] acc;
	logic [VAL_W:0] cnt;
	always_comb begin
		acc = '0;
		cnt = '0;
		for (int i = 0; i < LINES; i++) begin
			if (lines[i]) begin
				acc = acc | VAL_W'(i);
				cnt = cnt + (VAL_W+1)'(1);
			end
		end
		valid = (cnt == (VAL_W+1)'(1));
		value = valid ? acc : '0;
	end
endmodule
`default_nettype wire

// ---- verilog/dsr_top.sv ----
// Decade switch reader: transmitter selects a switch, receiver checks and converts its lines.
`timescale 1ns/1ns
`default_nettype none
// Function
// - The transmitter drives the query line of the one selected switch.
// - The receiver checks the returned decimal lines and converts them to binary.
// - Interrogation starts only through an output transfer to this module.
// - The value is collected by a separate input transfer to the receiver.
// - Exactly one of ten lines must be active, otherwise the reading is invalid.
// - The validity result is a single control-digit output.
// - The module answers to device class fifteen on the input busbars.
// - The binary value sits on the four least significant output busbars.
// - The clear strobe sets the switch number to zero.
// - The load strobe captures the switch number and queries that switch.
// - The gate-out strobe drives the converted value onto the data output.
// - The selected switch stays queried until another output transfer changes it.
// - Up to 24 switches by default, more by raising a parameter.
// - A deselect strobe clears the stored selection.
// - A select strobe compares the address with the class and selects on a class match.
module dsr_top #(
	parameter int NUM_SW = dsr_pkg::DSR_NUM_SW,
	parameter int SWNUM_W = dsr_pkg::DSR_SWNUM_W
) (
	input wire logic clk_sys, // System clock, 20 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [dsr_pkg::DSR_BUS_W-1:0] bus_in, // Input busbars.
	input wire logic output_device_select, // Select strobe, output side.
	input wire logic output_device_deselect, // Deselect strobe, output side.
	input wire logic input_device_select, // Select strobe, input side.
	input wire logic input_device_deselect, // Deselect strobe, input side.
	input wire logic switch_number_clear, // Clear switch number strobe.
	input wire logic switch_number_load, // Load switch number strobe.
	input wire logic reading_gate_out, // Gate reading to data output.
	input wire logic [dsr_pkg::DSR_LINES-1:0] decimal_lines, // Lines from remote switch.
	output logic [NUM_SW-1:0] switch_query_line, // One query line per switch.
	output logic [dsr_pkg::DSR_BUS_W-1:0] bus_out, // Output busbars.
	output logic bus_out_valid, // Output busbars carry data.
	output logic reading_valid // One-of-ten control digit.
);
	// Refuse sizes that the number register or the busbars cannot carry.
	if (NUM_SW < 1 || NUM_SW > (1 << SWNUM_W) || SWNUM_W > dsr_pkg::DSR_BUS_W) begin : g_bad_size
		$error("NUM_SW does not fit SWNUM_W");
	end
	////////////////////////////////////////////////////////////////////////////
	logic out_sel_q, in_sel_q;
	logic class_hit;
	assign class_hit = (bus_in[dsr_pkg::DSR_ADDR_W-1:0] == dsr_pkg::DSR_CLASS);
	always_ff @(posedge clk_sys) begin
		if (srst || output_device_deselect) begin
			out_sel_q <= 1'b0;
		end else if (output_device_select) begin
			out_sel_q <= class_hit;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst || input_device_deselect) begin
			in_sel_q <= 1'b0;
		end else if (input_device_select) begin
			in_sel_q <= class_hit;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Switch number register; the query stays up until another load or clear.
	logic [SWNUM_W-1:0] swnum_q;
	logic query_on_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			swnum_q <= SWNUM_W'(dsr_pkg::DSR_SWNUM_RST);
			query_on_q <= 1'b0;
		end else if (out_sel_q && switch_number_clear) begin
			swnum_q <= '0;
			query_on_q <= 1'b0;
		end else if (out_sel_q && switch_number_load) begin
			swnum_q <= bus_in[SWNUM_W-1:0];
			query_on_q <= 1'b1;
		end
	end
	genvar g;
	generate
		for (g = 0; g < NUM_SW; g++) begin : g_query
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					switch_query_line[g] <= 1'b0;
				end else begin
					switch_query_line[g] <= query_on_q && (swnum_q == SWNUM_W'(g));
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// Remote lines are asynchronous and pass two flip-flops.
	logic [dsr_pkg::DSR_LINES-1:0] lines_m_q, lines_s_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lines_m_q <= '0;
			lines_s_q <= '0;
		end else begin
			lines_m_q <= decimal_lines;
			lines_s_q <= lines_m_q;
		end
	end
	logic dec_valid;
	logic [dsr_pkg::DSR_VAL_W-1:0] dec_value;
	dsr_decoder #(.LINES(dsr_pkg::DSR_LINES), .VAL_W(dsr_pkg::DSR_VAL_W)) u_dec (
		.lines(lines_s_q),
		.valid(dec_valid),
		.value(dec_value)
	);
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reading_valid <= 1'b0;
		end else begin
			reading_valid <= dec_valid;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bus_out <= '0;
			bus_out_valid <= 1'b0;
		end else if (in_sel_q && reading_gate_out) begin
			bus_out <= {{(dsr_pkg::DSR_BUS_W-dsr_pkg::DSR_VAL_W){1'b0}}, dec_value};
			bus_out_valid <= 1'b1;
		end else begin
			bus_out <= '0;
			bus_out_valid <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Steps that the controller takes; some of the properties below are built from them.
	sequence s_load;
		out_sel_q && !switch_number_clear && switch_number_load;
	endsequence
	sequence s_load_in_range;
		s_load ##0 (int'(bus_in[SWNUM_W-1:0]) < NUM_SW);
	endsequence
	sequence s_load_out_range;
		s_load ##0 (int'(bus_in[SWNUM_W-1:0]) >= NUM_SW);
	endsequence
	sequence s_quiet;
		!(switch_number_load || switch_number_clear);
	endsequence
	sequence s_clear;
		out_sel_q && switch_number_clear;
	endsequence
	sequence s_gate;
		in_sel_q && reading_gate_out;
	endsequence
	sequence s_gate_one;
		s_gate ##0 $onehot(lines_s_q);
	endsequence
	sequence s_gate_bad;
		s_gate ##0 !$onehot(lines_s_q);
	endsequence

	a_load_query: assert property (@(posedge clk_sys) disable iff (srst)
		s_load_in_range |-> ##2 switch_query_line[$past(bus_in[SWNUM_W-1:0], 2)])
		else $error("load did not raise query line");

	a_load_range: assert property (@(posedge clk_sys) disable iff (srst)
		s_load_out_range |-> ##2 (switch_query_line == '0))
		else $error("number beyond the last switch raised a query line");

	a_query_onehot: assert property (@(posedge clk_sys) disable iff (srst)
		$onehot0(switch_query_line))
		else $error("more than one query line");

	a_query_holds: assert property (@(posedge clk_sys) disable iff (srst)
		s_quiet |-> ##2 $stable(switch_query_line))
		else $error("query line changed without transfer");

	a_query_refused: assert property (@(posedge clk_sys) disable iff (srst)
		!out_sel_q |-> ##2 $stable(switch_query_line))
		else $error("query line changed without selection");

	a_clear_zero: assert property (@(posedge clk_sys) disable iff (srst)
		s_clear |=> (swnum_q == '0 && !query_on_q) ##1 (switch_query_line == '0))
		else $error("clear did not zero number");

	a_no_start: assert property (@(posedge clk_sys) disable iff (srst)
		!out_sel_q |=> $stable(swnum_q))
		else $error("number changed without selection");

	a_valid_check: assert property (@(posedge clk_sys) disable iff (srst)
		##1 (reading_valid == $onehot($past(lines_s_q))))
		else $error("validity check wrong");

	a_gate_value: assert property (@(posedge clk_sys) disable iff (srst)
		s_gate_one |=> bus_out_valid && ((10'h001 << bus_out[dsr_pkg::DSR_VAL_W-1:0]) == $past(lines_s_q)))
		else $error("gated value wrong");

	a_gate_invalid: assert property (@(posedge clk_sys) disable iff (srst)
		s_gate_bad |=> bus_out_valid && (bus_out == '0))
		else $error("invalid reading was not gated as zero");

	a_gate_refused: assert property (@(posedge clk_sys) disable iff (srst)
		(!in_sel_q || !reading_gate_out) |=> !bus_out_valid && (bus_out == '0))
		else $error("busbars driven without a gate-out transfer");

	a_gate_pulse: assert property (@(posedge clk_sys) disable iff (srst)
		bus_out_valid |-> $past(in_sel_q && reading_gate_out))
		else $error("busbar strobe without a gate-out transfer");

	a_high_zero: assert property (@(posedge clk_sys) disable iff (srst)
		bus_out[dsr_pkg::DSR_BUS_W-1:dsr_pkg::DSR_VAL_W] == '0)
		else $error("upper busbars not zero");

	a_deselect: assert property (@(posedge clk_sys) disable iff (srst)
		input_device_deselect |=> !in_sel_q ##1 !bus_out_valid)
		else $error("deselect did not clear selection");

	a_out_deselect: assert property (@(posedge clk_sys) disable iff (srst)
		output_device_deselect |=> !out_sel_q)
		else $error("output deselect did not clear selection");

	a_class_sel: assert property (@(posedge clk_sys) disable iff (srst)
		output_device_select && !output_device_deselect |=> out_sel_q == $past(class_hit))
		else $error("selection does not follow class");

	a_in_class_sel: assert property (@(posedge clk_sys) disable iff (srst)
		input_device_select && !input_device_deselect |=> in_sel_q == $past(class_hit))
		else $error("input selection does not follow class");
endmodule
`default_nettype wire

// ---- bench/dsr_switch_model.sv ----
// Behavioural model of the remote decade switches answering their query lines.
`timescale 1ns/1ns
`default_nettype none
module dsr_switch_model #(
	parameter int NUM_SW = 24
) (
	input wire logic [NUM_SW-1:0] query, // Query lines from the reader.
	input wire logic [1:0] fault, // 0 normal, 1 extra line on, 2 no line on.
	output logic [9:0] lines // Decimal lines back to the reader.
);
	// Switch i is set to digit i mod 10; an unqueried bank energises no line.
	always_comb begin
		lines = 10'h000;
		for (int i = 0; i < NUM_SW; i++) begin
			if (query[i]) begin
				lines = lines | (10'h001 << (i % 10));
			end
		end
		if (fault == 2'h1) begin
			lines = lines | 10'h200;
		end
		if (fault == 2'h2) begin
			lines = 10'h000;
		end
	end
endmodule
`default_nettype wire

// ---- bench/decade_switch_reader_tb_top.sv ----
// Self-checking testbench of the decade switch reader.
`timescale 1ns/1ns
`default_nettype none
module decade_switch_reader_tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [6:0] stb = 7'h00;
	logic [17:0] bus_in = 18'h00000;
	logic [1:0] fault = 2'h0;
	logic [9:0] lines;
	logic [23:0] query;
	logic [17:0] bus_out;
	logic bus_out_valid;
	logic reading_valid;
	int err_count = 0;
	int n_checks = 0;
	always #25 clk_sys = ~clk_sys;
	dsr_top u_dsr_top (.clk_sys(clk_sys), .srst(srst), .bus_in(bus_in), .output_device_select(stb[0]),
		.output_device_deselect(stb[1]), .input_device_select(stb[2]), .input_device_deselect(stb[3]),
		.switch_number_clear(stb[4]), .switch_number_load(stb[5]), .reading_gate_out(stb[6]),
		.decimal_lines(lines), .switch_query_line(query), .bus_out(bus_out),
		.bus_out_valid(bus_out_valid), .reading_valid(reading_valid));
	dsr_switch_model u_dsr_switch_model (.query(query), .fault(fault), .lines(lines));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Bit k of stb is one strobe; it is held for exactly one sampling edge.
	task automatic strobe(input int k, input logic [17:0] b);
		@(posedge clk_sys);
		stb <= 7'h01 << k;
		bus_in <= b;
		@(posedge clk_sys);
		stb <= 7'h00;
	endtask
	task automatic query_is(input int n);
		repeat (2) @(posedge clk_sys);
		#1 chk(32'(query), (32'h1 << n) & 32'hFFFFFF);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic read_sw(input int n, input int dig, input logic ok);
		strobe(1, 18'h00000);
		strobe(0, 18'h0000F);
		strobe(5, 18'(n));
		query_is(n);
		repeat (4) @(posedge clk_sys);
		#1 chk(32'(reading_valid), 32'(ok));
		strobe(3, 18'h00000);
		strobe(2, 18'h0000F);
		strobe(6, 18'h00000);
		#1 chk(32'(bus_out), ok ? 32'(dig) : 32'h0);
		chk(32'(bus_out_valid), 32'h1);
		@(posedge clk_sys);
		#1 chk(32'(bus_out), 32'h0);
	endtask
	task automatic refusals();
		read_sw(7, 7, 1'b1);
		strobe(1, 18'h00000);
		strobe(0, 18'h0000E);
		strobe(5, 18'h00002);
		query_is(7);
		strobe(1, 18'h00000);
		strobe(5, 18'h00004);
		query_is(7);
		strobe(3, 18'h00000);
		strobe(6, 18'h00000);
		#1 chk(32'(bus_out_valid), 32'h0);
		strobe(0, 18'h0000F);
		strobe(4, 18'h00000);
		query_is(24);
	endtask
	// Clear and load together: clear wins; select and deselect together: deselect wins.
	task automatic contention();
		strobe(0, 18'h0000F);
		@(posedge clk_sys);
		stb <= 7'h30;
		bus_in <= 18'h00005;
		@(posedge clk_sys);
		stb <= 7'h00;
		query_is(24);
		@(posedge clk_sys);
		stb <= 7'h03;
		bus_in <= 18'h0000F;
		@(posedge clk_sys);
		stb <= 7'h00;
		strobe(5, 18'h00006);
		query_is(24);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		for (int n = 0; n < 10; n++) begin
			read_sw(n, n, 1'b1);
		end
		read_sw(23, 3, 1'b1);
		read_sw(24, 0, 1'b0);
		fault <= 2'h1;
		read_sw(3, 3, 1'b0);
		fault <= 2'h2;
		read_sw(5, 5, 1'b0);
		fault <= 2'h0;
		refusals();
		contention();
		wrap_up();
	end
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
